// *** include/ubm_pkg.sv ***
// ubm_pkg: register map, field layouts and codes of the serial port
package ubm_pkg;

  localparam logic [7:0] ADDR_CTRL_HIGH  = 8'hf2;
  localparam logic [7:0] ADDR_CTRL_LOW   = 8'hf3;
  localparam logic [7:0] ADDR_SHIFT_DATA = 8'hf4;
  localparam logic [7:0] ADDR_BAUD_DIV   = 8'hf5;

  localparam logic [7:0] RST_CTRL_HIGH   = 8'h00;
  localparam logic [7:0] RST_CTRL_LOW    = 8'h00;
  localparam logic [7:0] RST_SHIFT_DATA  = 8'h00;
  localparam logic [7:0] RST_BAUD_DIV    = 8'h00;
  localparam logic [2:0] RST_PRESCALE    = 3'h0;

  // pending flag sits at bit 0 of both control registers
  localparam int unsigned POS_PEND       = 0;

  // oversampling: sixteen ticks per bit
  localparam logic [3:0] OS_LAST         = 4'hf;
  localparam logic [3:0] OS_MID          = 4'h7;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // prescaler masks for system clock / 8, 4, 2, 1
  localparam logic [2:0] PRE_MASK_DIV8   = 3'h7;
  localparam logic [2:0] PRE_MASK_DIV4   = 3'h3;
  localparam logic [2:0] PRE_MASK_DIV2   = 3'h1;
  localparam logic [2:0] PRE_MASK_DIV1   = 3'h0;

  typedef enum logic [1:0] {
    MODE_SYNC   = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_FIX9   = 2'b10,
    MODE_VAR9   = 2'b11
  } ubm_mode_e;

  typedef enum logic [1:0] {
    CLK_DIV8 = 2'b00,
    CLK_DIV4 = 2'b01,
    CLK_DIV2 = 2'b10,
    CLK_DIV1 = 2'b11
  } ubm_clksel_e;

  typedef struct packed {
    ubm_mode_e mode;
    logic      rsv;
    logic      rx_enable;
    logic      tx_ninth_bit;
    logic      rx_ninth_bit;
    logic      rx_int_en;
    logic      rx_pend;
  } ubm_ctrl_high_s;

  typedef struct packed {
    logic        par_en;
    logic        par_odd;
    logic        rx_par_odd;
    logic        rsv;
    ubm_clksel_e clk_sel;
    logic        tx_int_en;
    logic        tx_pend;
  } ubm_ctrl_low_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ubm_req_s;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_NINTH = 3'b011,
    TX_STOP  = 3'b100,
    TX_SYNC  = 3'b101
  } ubm_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_NINTH = 3'b011,
    RX_STOP  = 3'b100
  } ubm_rx_e;

endpackage : ubm_pkg

// *** rtl/ubm_rate_div.sv ***
// ubm_rate_div: oversampling tick divider of the serial port
`timescale 1ns/10ps
`default_nettype none

module ubm_rate_div #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic         tick_i,
  input  wire logic         fixed_i,
  input  wire logic [W-1:0] div_i,
  output logic              os_tick_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         os_d;

  // one tick per (div + 1) clock ticks, or every tick when fixed
  always_comb begin
    cnt_d = cnt_q;
    os_d  = 1'b0;
    if (tick_i) begin
      if (fixed_i || cnt_q >= div_i) begin
        cnt_d = '0;
        os_d  = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q     <= '0;
      os_tick_o <= 1'b0;
    end else if (ce_i) begin
      cnt_q     <= cnt_d;
      os_tick_o <= os_d;
    end
  end

  chk_fixed_rate: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && tick_i && fixed_i |=> os_tick_o)
    else $error("fixed rate tick missing");

  chk_div_period: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ce_i && tick_i && !fixed_i |=> os_tick_o == ($past(cnt_q) >= $past(div_i)))
    else $error("divider tick at wrong count");

endmodule : ubm_rate_div

`default_nettype wire

// *** rtl/ubm_uart.sv ***
// ubm_uart: serial port with sync shift mode and 10/11-bit frames
`timescale 1ns/10ps
`default_nettype none

module ubm_uart (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  input  wire ubm_pkg::ubm_req_s req_i,
  output logic [7:0]             rdata_o,
  input  wire logic              serial_in_pin_i,
  output logic                   serial_in_pin_o,
  output logic                   serial_in_pin_oe_o,
  output logic                   serial_out_pin_o
);
  import ubm_pkg::*;

  function automatic logic has_ninth(input ubm_mode_e m);
    has_ninth = (m == MODE_FIX9) || (m == MODE_VAR9);
  endfunction : has_ninth

  function automatic logic [2:0] pre_mask(input ubm_clksel_e s);
    case (s)
      CLK_DIV8: pre_mask = PRE_MASK_DIV8;
      CLK_DIV4: pre_mask = PRE_MASK_DIV4;
      CLK_DIV2: pre_mask = PRE_MASK_DIV2;
      default:  pre_mask = PRE_MASK_DIV1;
    endcase
  endfunction : pre_mask

  ubm_ctrl_high_s ch_q;
  ubm_ctrl_high_s ch_d;
  ubm_ctrl_low_s  cl_q;
  ubm_ctrl_low_s  cl_d;
  logic [7:0]     div_q;
  logic [7:0]     div_d;
  logic [7:0]     rxbuf_q;
  logic [7:0]     rxbuf_d;
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  logic [2:0]     pre_q;
  logic [2:0]     pre_d;
  logic [2:0]     sync_q;
  logic           filt_q;
  logic           filt_d;
  logic           uclk_tick;
  logic           os_tick;
  logic           wr_data;
  ubm_tx_e        tst_q;
  ubm_tx_e        tst_d;
  logic [3:0]     tos_q;
  logic [3:0]     tos_d;
  logic [2:0]     tbit_q;
  logic [2:0]     tbit_d;
  logic [7:0]     tsh_q;
  logic [7:0]     tsh_d;
  logic           tnine_q;
  logic           tnine_d;
  logic           out_q;
  logic           out_d;
  logic           drv_q;
  logic           drv_d;
  logic           s0rx_q;
  logic           s0rx_d;
  logic           tx_done;
  logic           m0_rx_done;
  ubm_rx_e        rst_q;
  ubm_rx_e        rst_d;
  logic [3:0]     ros_q;
  logic [3:0]     ros_d;
  logic [2:0]     rbit_q;
  logic [2:0]     rbit_d;
  logic [7:0]     rsh_q;
  logic [7:0]     rsh_d;
  logic           rprev_q;
  logic           rprev_d;
  logic           a_rx_done;
  logic           nine_we;
  logic           rx_go;
  logic           rx_done;
  logic [7:0]     rx_byte;

  assign wr_data            = req_i.wr && req_i.addr == ADDR_SHIFT_DATA;
  assign rx_done            = m0_rx_done || a_rx_done;
  assign rx_byte            = m0_rx_done ? tsh_q : rsh_q;
  assign rdata_o            = rdata_q;
  assign serial_in_pin_o    = tsh_q[0];
  assign serial_in_pin_oe_o = drv_q;
  assign serial_out_pin_o   = out_q;

  // ---- prescaler and receive pin synchroniser
  always_comb begin
    pre_d     = pre_q + 3'h1;
    uclk_tick = (pre_q & pre_mask(cl_q.clk_sel)) == pre_mask(cl_q.clk_sel);
    // a level change counts once the last two stages agree
    filt_d    = (sync_q[1] == sync_q[2]) ? sync_q[1] : filt_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pre_q  <= RST_PRESCALE;
      sync_q <= 3'h7;
      filt_q <= 1'b1;
    end else if (ce_i) begin
      pre_q  <= pre_d;
      sync_q <= {sync_q[1:0], serial_in_pin_i};
      filt_q <= filt_d;
    end
  end

  // 16x tick; 9-bit fixed mode ignores the divisor
  ubm_rate_div #(
    .W (8)
  ) u_rate_div (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .tick_i    (uclk_tick),
    .fixed_i   (ch_q.mode == MODE_FIX9),
    .div_i     (div_q),
    .os_tick_o (os_tick)
  );

  // ---- register file
  always_comb begin
    ch_d    = ch_q;
    cl_d    = cl_q;
    div_d   = div_q;
    rxbuf_d = rxbuf_q;
    rdata_d = 8'h00;
    if (req_i.wr) begin
      if (req_i.addr == ADDR_CTRL_HIGH) begin
        ch_d              = ubm_ctrl_high_s'(req_i.wdata);
        ch_d.rsv          = 1'b0;
        ch_d.rx_ninth_bit = ch_q.rx_ninth_bit;
        // writing 0 clears the flag, writing 1 leaves it
        ch_d.rx_pend      = ch_q.rx_pend && req_i.wdata[POS_PEND];
      end else if (req_i.addr == ADDR_CTRL_LOW) begin
        cl_d         = ubm_ctrl_low_s'(req_i.wdata);
        cl_d.rsv     = 1'b0;
        cl_d.tx_pend = cl_q.tx_pend && req_i.wdata[POS_PEND];
      end else if (req_i.addr == ADDR_BAUD_DIV) begin
        div_d = req_i.wdata;
      end
    end
    // hardware set wins over a clear in the same cycle
    if (tx_done) begin
      cl_d.tx_pend = 1'b1;
    end
    if (rx_done) begin
      ch_d.rx_pend = 1'b1;
      rxbuf_d      = rx_byte;
    end
    if (nine_we) begin
      ch_d.rx_ninth_bit = filt_q;
    end
    if (req_i.rd) begin
      if (req_i.addr == ADDR_CTRL_HIGH) begin
        rdata_d = ch_q;
      end else if (req_i.addr == ADDR_CTRL_LOW) begin
        rdata_d = cl_q;
      end else if (req_i.addr == ADDR_SHIFT_DATA) begin
        rdata_d = rxbuf_q;
      end else if (req_i.addr == ADDR_BAUD_DIV) begin
        rdata_d = div_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ch_q    <= ubm_ctrl_high_s'(RST_CTRL_HIGH);
      cl_q    <= ubm_ctrl_low_s'(RST_CTRL_LOW);
      div_q   <= RST_BAUD_DIV;
      rxbuf_q <= RST_SHIFT_DATA;
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      ch_q    <= ch_d;
      cl_q    <= cl_d;
      div_q   <= div_d;
      rxbuf_q <= rxbuf_d;
      rdata_q <= rdata_d;
    end
  end

  // ---- transmitter and sync-mode shifter
  always_comb begin
    tst_d      = tst_q;
    tos_d      = tos_q;
    tbit_d     = tbit_q;
    tsh_d      = tsh_q;
    tnine_d    = tnine_q;
    out_d      = out_q;
    drv_d      = drv_q;
    s0rx_d     = s0rx_q;
    tx_done    = 1'b0;
    m0_rx_done = 1'b0;
    case (tst_q)
      TX_IDLE: begin
        out_d  = 1'b1;
        drv_d  = 1'b0;
        tos_d  = 4'h0;
        tbit_d = 3'h0;
        if (wr_data) begin
          tsh_d   = req_i.wdata;
          // parity only matters in 9-bit modes
          tnine_d = cl_q.par_en ? (^req_i.wdata) ^ cl_q.par_odd
                                : ch_q.tx_ninth_bit;
          out_d   = 1'b0;
          if (ch_q.mode == MODE_SYNC) begin
            tst_d  = TX_SYNC;
            s0rx_d = 1'b0;
            drv_d  = 1'b1;
          end else begin
            tst_d = TX_START;
          end
        end else if (ch_q.mode == MODE_SYNC && ch_q.rx_enable &&
                     !ch_q.rx_pend) begin
          tst_d  = TX_SYNC;
          s0rx_d = 1'b1;
          out_d  = 1'b0;
        end
      end
      TX_START: begin
        if (os_tick) begin
          tos_d = tos_q + 4'h1;
          if (tos_q == OS_LAST) begin
            tst_d = TX_DATA;
            out_d = tsh_q[0];
          end
        end
      end
      TX_DATA: begin
        if (os_tick) begin
          tos_d = tos_q + 4'h1;
          if (tos_q == OS_LAST) begin
            tbit_d = tbit_q + 3'h1;
            tsh_d  = {1'b0, tsh_q[7:1]};
            out_d  = tsh_q[1];
            if (tbit_q == BIT_LAST) begin
              if (has_ninth(ch_q.mode)) begin
                tst_d = TX_NINTH;
                out_d = tnine_q;
              end else begin
                tst_d   = TX_STOP;
                out_d   = 1'b1;
                tx_done = 1'b1;
              end
            end
          end
        end
      end
      TX_NINTH: begin
        if (os_tick) begin
          tos_d = tos_q + 4'h1;
          if (tos_q == OS_LAST) begin
            tst_d   = TX_STOP;
            out_d   = 1'b1;
            tx_done = 1'b1;
          end
        end
      end
      TX_STOP: begin
        if (os_tick) begin
          tos_d = tos_q + 4'h1;
          if (tos_q == OS_LAST) begin
            tst_d = TX_IDLE;
          end
        end
      end
      TX_SYNC: begin
        if (os_tick) begin
          tos_d = tos_q + 4'h1;
          if (tos_q == OS_MID) begin
            out_d = 1'b1; // rising clock: sample point
            if (s0rx_q) begin
              tsh_d = {filt_q, tsh_q[7:1]};
            end
          end
          if (tos_q == OS_LAST) begin
            out_d  = 1'b0; // falling clock: data change
            tbit_d = tbit_q + 3'h1;
            if (!s0rx_q) begin
              tsh_d = {1'b0, tsh_q[7:1]};
            end
            if (tbit_q == BIT_LAST) begin
              tst_d = TX_IDLE;
              out_d = 1'b1;
              drv_d = 1'b0;
              if (s0rx_q) begin
                m0_rx_done = 1'b1;
              end else begin
                tx_done = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        tst_d = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tst_q   <= TX_IDLE;
      tos_q   <= 4'h0;
      tbit_q  <= 3'h0;
      tsh_q   <= 8'h00;
      tnine_q <= 1'b0;
      out_q   <= 1'b1;
      drv_q   <= 1'b0;
      s0rx_q  <= 1'b0;
    end else if (ce_i) begin
      tst_q   <= tst_d;
      tos_q   <= tos_d;
      tbit_q  <= tbit_d;
      tsh_q   <= tsh_d;
      tnine_q <= tnine_d;
      out_q   <= out_d;
      drv_q   <= drv_d;
      s0rx_q  <= s0rx_d;
    end
  end

  // ---- asynchronous receiver
  assign rx_go = ch_q.rx_enable && ch_q.mode != MODE_SYNC;

  always_comb begin
    rst_d     = rst_q;
    ros_d     = ros_q;
    rbit_d    = rbit_q;
    rsh_d     = rsh_q;
    rprev_d   = rprev_q;
    a_rx_done = 1'b0;
    nine_we   = 1'b0;
    if (os_tick) begin
      ros_d = ros_q + 4'h1;
    end
    case (rst_q)
      RX_IDLE: begin
        ros_d = 4'h0;
        if (os_tick) begin
          rprev_d = filt_q;
          // mode 1 starts on a low level, 9-bit modes on a fall
          if (rx_go && !filt_q &&
              (ch_q.mode == MODE_ASYNC8 || rprev_q)) begin
            rst_d = RX_START;
          end
        end
      end
      RX_START: begin
        if (os_tick && ros_q == OS_MID) begin
          ros_d  = 4'h0;
          rbit_d = 3'h0;
          // a start bit gone high by mid-bit was a glitch
          rst_d  = filt_q ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (os_tick && ros_q == OS_LAST) begin
          rsh_d  = {filt_q, rsh_q[7:1]};
          rbit_d = rbit_q + 3'h1;
          if (rbit_q == BIT_LAST) begin
            rst_d = has_ninth(ch_q.mode) ? RX_NINTH : RX_STOP;
          end
        end
      end
      RX_NINTH: begin
        if (os_tick && ros_q == OS_LAST) begin
          nine_we   = 1'b1;
          a_rx_done = 1'b1;
          rprev_d   = 1'b0;
          rst_d     = RX_IDLE;
        end
      end
      RX_STOP: begin
        if (os_tick && ros_q == OS_LAST) begin
          a_rx_done = 1'b1;
          rprev_d   = 1'b0;
          rst_d     = RX_IDLE;
        end
      end
      default: begin
        rst_d = RX_IDLE;
      end
    endcase
    if (!rx_go && rst_q != RX_IDLE) begin
      rst_d     = RX_IDLE;
      a_rx_done = 1'b0;
      nine_we   = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rst_q   <= RX_IDLE;
      ros_q   <= 4'h0;
      rbit_q  <= 3'h0;
      rsh_q   <= 8'h00;
      rprev_q <= 1'b0;
    end else if (ce_i) begin
      rst_q   <= rst_d;
      ros_q   <= ros_d;
      rbit_q  <= rbit_d;
      rsh_q   <= rsh_d;
      rprev_q <= rprev_d;
    end
  end

  // ---- assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_div_wr;
    ce_i && req_i.wr && req_i.addr == ADDR_BAUD_DIV;
  endsequence
  sequence s_div_rd;
    ce_i && req_i.rd && !req_i.wr && req_i.addr == ADDR_BAUD_DIV;
  endsequence
  sequence s_m0_launch;
    ce_i && wr_data && tst_q == TX_IDLE && ch_q.mode == MODE_SYNC;
  endsequence

  chk_div_readback: assert property (
    s_div_wr ##2 s_div_rd |=> rdata_o == $past(req_i.wdata, 3))
    else $error("divisor readback mismatch");
  chk_tx_launch: assert property (
    ce_i && wr_data && tst_q == TX_IDLE && ch_q.mode == MODE_ASYNC8
    |=> !serial_out_pin_o && tst_q == TX_START)
    else $error("frame did not start with a low start bit");
  chk_sync_launch: assert property (
    s_m0_launch |=> serial_in_pin_oe_o && !serial_out_pin_o &&
                    serial_in_pin_o == $past(req_i.wdata[0]))
    else $error("sync send did not drive lsb with clock low");
  chk_sync_rx_idle: assert property (
    tst_q == TX_SYNC && s0rx_q |-> !serial_in_pin_oe_o)
    else $error("data pin driven during sync receive");
  chk_pend_clear: assert property (
    ce_i && req_i.wr && req_i.addr == ADDR_CTRL_HIGH &&
    !req_i.wdata[POS_PEND] && !rx_done |=> !ch_q.rx_pend)
    else $error("receive pending not cleared by write of 0");
  chk_rx_set_wins: assert property (
    ce_i && rx_done |=> ch_q.rx_pend && rxbuf_q == $past(rx_byte))
    else $error("receive completion lost");
  chk_tx_pend_stop: assert property (
    ce_i && tx_done && ch_q.mode != MODE_SYNC
    |=> cl_q.tx_pend && serial_out_pin_o && tst_q == TX_STOP)
    else $error("transmit pending not at stop bit start");
  chk_ninth_line: assert property (
    tst_q == TX_NINTH |-> serial_out_pin_o == tnine_q)
    else $error("ninth bit not on the line");
  chk_parity_gen: assert property (
    ce_i && wr_data && tst_q == TX_IDLE && cl_q.par_en
    |=> tnine_q == ((^$past(req_i.wdata)) ^ $past(cl_q.par_odd)))
    else $error("parity ninth bit wrong");
  chk_stop_high: assert property (
    tst_q == TX_STOP |-> serial_out_pin_o)
    else $error("stop bit not high");

endmodule : ubm_uart

`default_nettype wire

// *** sim/ubm_far_end.sv ***
// ubm_far_end: remote serial device model facing the serial port
`timescale 1ns/10ps
`default_nettype none

module ubm_far_end (
  input  wire logic clk_i,
  input  wire logic line_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  output logic      pin_o
);
  logic [7:0] sbyte;
  logic [7:0] scap;
  int         sidx;
  logic       sync_en;
  realtime    t0;
  realtime    t1;

  // data pin has a pull-up, so released means high
  initial begin
    pin_o   = 1'b1;
    sync_en = 1'b0;
    sidx    = 8;
    t0      = 0;
  end

  // async frame out, bit 0 first, idle high after
  task send(input logic [10:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      pin_o <= f[i];
      repeat (bt) @(posedge clk_i);
    end
    pin_o <= 1'b1;
  endtask : send

  // sample a frame from the device at bit centres
  task grab(input int n, input int bt, output logic [10:0] f);
    f = '0;
    @(negedge line_i);
    repeat (bt / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      #1 f[i] = line_i;
      if (i < n - 1) repeat (bt) @(posedge clk_i);
    end
  endtask : grab

  // sync slave: next bit after falling shift clock
  always @(negedge line_i) begin
    if (sync_en) begin
      pin_o <= (sidx < 8) ? sbyte[sidx] : 1'b1;
      sidx  <= sidx + 1;
    end
  end

  // capture device data on rising shift clock
  always @(posedge line_i) begin
    if (oe_i) begin
      scap <= {pin_i, scap[7:1]};
      if (t0 == 0) t0 <= $realtime;
      t1 <= $realtime;
    end
    // released data pin returns to its pull-up after the last bit
    if (sync_en && sidx >= 8) pin_o <= 1'b1;
  end
endmodule : ubm_far_end

`default_nettype wire

// *** sim/ubm_uart_tb.sv ***
// ubm_uart_tb: self-checking bench of the serial port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end

module ubm_uart_tb;
  import ubm_pkg::*;
  logic        clk_i;
  logic        rstn_i;
  logic        ce;
  ubm_req_s    req;
  logic [7:0]  rdata;
  logic [7:0]  rd_v;
  logic        dev_o;
  logic        dev_oe;
  logic        tx_line;
  logic        far_o;
  logic        dpin;
  logic [10:0] fr;
  int          span;
  int          fail_count = 0;
  int          checked = 0;

  assign dpin = dev_oe ? dev_o : far_o;

  ubm_uart DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .req_i(req),
    .rdata_o(rdata), .serial_in_pin_i(dpin), .serial_in_pin_o(dev_o),
    .serial_in_pin_oe_o(dev_oe), .serial_out_pin_o(tx_line));
  ubm_far_end FAR (.clk_i(clk_i), .line_i(tx_line), .pin_i(dpin),
    .oe_i(dev_oe), .pin_o(far_o));

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    req <= '0;
  endtask : wr

  task chk_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    req <= '0;
    #1 rd_v = rdata;
    `CHK(nm, e, rd_v)
  endtask : chk_reg

  task a_tx(input logic [7:0] ch, cl, d, input int n, bt,
            input logic [10:0] e);
    wr(ADDR_CTRL_LOW, cl);
    wr(ADDR_CTRL_HIGH, ch);
    fork
      FAR.grab(n, bt, fr);
      wr(ADDR_SHIFT_DATA, d);
    join
    `CHK("frame", e, fr)
    chk_reg("tx pend", ADDR_CTRL_LOW, cl | 8'h01);
    wr(ADDR_CTRL_LOW, cl);
    repeat (bt) @(posedge clk_i);
    $display("test async send done");
  endtask : a_tx

  task a_rx(input logic [7:0] ch, input logic [10:0] f, input int n, bt,
            input logic [7:0] e, eh);
    wr(ADDR_CTRL_HIGH, ch);
    FAR.send(f, n, bt);
    repeat (bt) @(posedge clk_i);
    chk_reg("rx data", ADDR_SHIFT_DATA, e);
    chk_reg("rx flags", ADDR_CTRL_HIGH, eh);
    $display("test async receive done");
  endtask : a_rx

  task finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    #400000;
    fail_count++;
    finish_test();
  end

  initial begin
    rstn_i = 1'b0;
    req    = '0;
    ce     = 1'b1;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk_reg("divisor rst", ADDR_BAUD_DIV, 8'h00);
    chk_reg("unmapped", 8'hf0, 8'h00);
    wr(ADDR_BAUD_DIV, 8'h01);
    chk_reg("divisor", ADDR_BAUD_DIV, 8'h01);
    // a write while the clock enable is low must not be taken
    ce <= 1'b0;
    wr(ADDR_BAUD_DIV, 8'h33);
    ce <= 1'b1;
    chk_reg("divisor frozen", ADDR_BAUD_DIV, 8'h01);
    $display("test registers done");
    // divisor 1 at clk/1: 32 clocks a bit, mode 2 always 16
    a_tx(8'h40, 8'h0c, 8'ha5, 10, 32, {1'b0, 1'b1, 8'ha5, 1'b0});
    a_tx(8'h88, 8'h0c, 8'h3c, 11, 16, {1'b1, 1'b1, 8'h3c, 1'b0});
    a_tx(8'h88, 8'hcc, 8'h07, 11, 16, {1'b1, 1'b0, 8'h07, 1'b0});
    // mode 3 at clk/2, divisor 1: 64 clocks a bit
    a_tx(8'hc0, 8'h08, 8'h5e, 11, 64, {1'b1, 1'b0, 8'h5e, 1'b0});
    wr(ADDR_CTRL_LOW, 8'h0c);
    a_rx(8'h50, {1'b0, 1'b1, 8'h5a, 1'b0}, 10, 32, 8'h5a, 8'h51);
    a_rx(8'h90, {1'b0, 1'b1, 8'hc3, 1'b0}, 11, 16, 8'hc3, 8'h95);
    wr(ADDR_CTRL_HIGH, 8'h00);
    chk_reg("pend clear", ADDR_CTRL_HIGH, 8'h04);
    wr(ADDR_SHIFT_DATA, 8'h96);
    repeat (400) @(posedge clk_i);
    `CHK("sync out", 8'h96, FAR.scap)
    span = int'(FAR.t1 - FAR.t0);
    `CHK("sync span", 4480, span)
    chk_reg("sync tx pend", ADDR_CTRL_LOW, 8'h0d);
    $display("test sync send done");
    FAR.sbyte   = 8'h3b;
    FAR.sidx    = 0;
    FAR.sync_en = 1'b1;
    wr(ADDR_CTRL_HIGH, 8'h10);
    repeat (400) @(posedge clk_i);
    wr(ADDR_CTRL_HIGH, 8'h01);
    FAR.sync_en = 1'b0;
    chk_reg("sync rx", ADDR_SHIFT_DATA, 8'h3b);
    chk_reg("sync rx pend", ADDR_CTRL_HIGH, 8'h05);
    $display("test sync receive done");
    finish_test();
  end
endmodule : ubm_uart_tb

`default_nettype wire
